// *** qdc_counter.sv ***
// qdc_counter.sv: 32-bit quadrature / up-down position counter with apb registers.
// assumes one 250 MHz clock, an apb master on that clock and asynchronous pins.
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "qdc_params.svh"

// Operation
// R01 - one 32-bit position count register
// R02 - general up/down count modes from events
// R03 - decode two inputs, quadrature or binary
// R04 - direction pin level selects up or down
// R05 - separate up and down edge detectors
// R06 - third input: zero marker or button
// R07 - programmable debounce on all three inputs
// R08 - forward count events to a timer
// R09 - boundary reached in auto-zero clears count; the code clears it only when a step passes maxb_reg or minb_reg
// R10 - interrupt when count passes a boundary
// R11 - synchronise inputs before debounce and decode
// R12 - one count per gray step, skip jumps
module qdc_counter
  import qdc_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic [2:0]  i_position_counter_inputs,
  output logic             o_irq,
  output qdc_evt_t         o_timer_evt
);

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] qdc_merge(input logic [31:0] old_v,
                                            input logic [31:0] wd,
                                            input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // decoded bus access
  logic        wr_en;
  logic        rd_en;
  logic        addr_ok;
  logic [31:0] rdata_next;

  // software registers
  logic [5:0]  ctrl_reg;
  logic [31:0] position_counter_reg;
  logic [31:0] maxb_reg;
  logic [31:0] minb_reg;
  logic [15:0] debounce_reg;
  logic [`QDC_ST_W-1:0] status_reg;
  logic [`QDC_ST_W-1:0] mask_reg;

  // input conditioning
  logic [2:0]  sync1_reg;
  logic [2:0]  sync2_reg;
  logic [7:0]  tick_cnt_reg;
  logic        tick;
  logic [15:0] deb_cnt_reg [3];
  qdc_pins_t   pins_reg;
  qdc_pins_t   pins_prev_reg;

  // count decisions
  qdc_mode_t   mode;
  logic        step_up;
  logic        step_dn;
  logic        illegal;
  logic        zero_hit;
  logic [31:0] count_next;
  logic        max_hit;
  logic        min_hit;
  logic [`QDC_ST_W-1:0] st_set;
  logic [`QDC_ST_W-1:0] st_clr;
  logic [31:0] wr_ctrl;
  logic [31:0] wr_dbn;
  logic [31:0] wr_mask;

  assign mode = qdc_mode_t'(ctrl_reg[`QDC_CTRL_MODE_HI:`QDC_CTRL_MODE_LO]);

  // apb decode: a write commits at the edge where the master sees pready high
  assign wr_en   = i_psel && i_penable && i_pwrite && o_pready;
  assign rd_en   = i_psel && i_penable && !i_pwrite && !o_pready;
  assign addr_ok = (i_paddr[11:5] == 7'h00) && (i_paddr[1:0] == 2'h0);

  // write data merged into each narrow register by byte lane
  assign wr_ctrl = qdc_merge({26'h0, ctrl_reg}, i_pwdata, i_pstrb);
  assign wr_dbn  = qdc_merge({16'h0, debounce_reg}, i_pwdata, i_pstrb);
  assign wr_mask = qdc_merge({26'h0, mask_reg}, i_pwdata, i_pstrb);

  // read mux
  always_comb begin
    rdata_next = 32'h00000000;
    unique case (i_paddr)
      `QDC_OFS_CTRL:     rdata_next = {26'h0000000, ctrl_reg};
      `QDC_OFS_COUNT:    rdata_next = position_counter_reg;
      `QDC_OFS_MAXB:     rdata_next = maxb_reg;
      `QDC_OFS_MINB:     rdata_next = minb_reg;
      `QDC_OFS_DEBOUNCE: rdata_next = {16'h0000, debounce_reg};
      `QDC_OFS_STATUS:   rdata_next = {26'h0000000, status_reg};
      `QDC_OFS_MASK:     rdata_next = {26'h0000000, mask_reg};
      `QDC_OFS_INPUTS:   rdata_next = {29'h00000000, pins_reg};
      default:           rdata_next = 32'h00000000;
    endcase
  end

  // apb answer: one wait cycle, then pready with data or slverr
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h00000000;
    end else begin
      o_pready  <= i_psel && i_penable && !o_pready;
      o_pslverr <= i_psel && i_penable && !o_pready && !addr_ok;
      if (rd_en || (i_psel && i_penable && !o_pready && !addr_ok)) begin
        o_prdata <= addr_ok ? rdata_next : 32'h00000000;
      end
    end
  end

  // control and limit registers
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_reg     <= `QDC_RST_CTRL;
      maxb_reg     <= `QDC_RST_MAXB;
      minb_reg     <= `QDC_RST_MINB;
      debounce_reg <= `QDC_RST_DEBOUNCE;
      mask_reg     <= '0;
    end else if (wr_en && addr_ok) begin
      unique case (i_paddr)
        `QDC_OFS_CTRL:     ctrl_reg <= wr_ctrl[5:0];
        `QDC_OFS_MAXB:     maxb_reg <= qdc_merge(maxb_reg, i_pwdata, i_pstrb); // R09
        `QDC_OFS_MINB:     minb_reg <= qdc_merge(minb_reg, i_pwdata, i_pstrb); // R09
        `QDC_OFS_DEBOUNCE: debounce_reg <= wr_dbn[15:0]; // R07
        `QDC_OFS_MASK:     mask_reg <= wr_mask[`QDC_ST_W-1:0];
        default: ;
      endcase
    end
  end

  // two-flop synchroniser on the pins
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else begin
      sync1_reg <= i_position_counter_inputs; // R11
      sync2_reg <= sync1_reg; // R11
    end
  end

  // debounce time base, one enable pulse per microsecond
  assign tick = (tick_cnt_reg == 8'(`QDC_TICK_CYC - 1));
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      tick_cnt_reg <= 8'h00;
    end else begin
      tick_cnt_reg <= tick ? 8'h00 : tick_cnt_reg + 8'h01;
    end
  end

  // per-input debounce: new level taken after it holds for debounce_reg ticks
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pins_reg <= '0;
      for (int i = 0; i < 3; i++) begin
        deb_cnt_reg[i] <= 16'h0000;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (sync2_reg[i] == pins_reg[i]) begin
          deb_cnt_reg[i] <= 16'h0000; // R07
        end else if (deb_cnt_reg[i] >= debounce_reg) begin
          pins_reg[i]    <= sync2_reg[i]; // R07
          deb_cnt_reg[i] <= 16'h0000;
        end else if (tick) begin
          deb_cnt_reg[i] <= deb_cnt_reg[i] + 16'h0001;
        end
      end
    end
  end

  // previous debounced levels for edge and transition detection
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pins_prev_reg <= '0;
    end else begin
      pins_prev_reg <= pins_reg;
    end
  end

  // step decode for each mode
  always_comb begin
    logic [1:0] old_c;
    logic [1:0] new_c;
    old_c   = {pins_prev_reg.b, pins_prev_reg.a};
    new_c   = {pins_reg.b, pins_reg.a};
    step_up = 1'b0;
    step_dn = 1'b0;
    illegal = 1'b0;
    unique case (mode)
      QDC_QUAD: begin
        // gray sequence 00-01-11-10 counts up
        if (old_c != new_c) begin
          if ((old_c ^ new_c) == 2'h3) begin
            illegal = 1'b1; // R12
          end else if ({old_c, new_c} == 4'h1 || {old_c, new_c} == 4'h7 ||
                       {old_c, new_c} == 4'he || {old_c, new_c} == 4'h8) begin
            step_up = 1'b1; // R03 R12
          end else begin
            step_dn = 1'b1; // R03 R12
          end
        end
      end
      QDC_BIN: begin
        // binary code: +1 or -1 modulo four, other jumps not counted but flagged illegal
        if (new_c == old_c + 2'h1) begin
          step_up = 1'b1; // R03
        end else if (new_c == old_c - 2'h1) begin
          step_dn = 1'b1; // R03
        end else if (new_c != old_c) begin
          illegal = 1'b1;
        end
      end
      QDC_DIR: begin
        // rising edge on a counts, b level gives direction
        if (pins_reg.a && !pins_prev_reg.a) begin
          step_up = !pins_reg.b; // R02 R04
          step_dn = pins_reg.b; // R02 R04
        end
      end
      QDC_UPDN: begin
        // a rising edges count up, b rising edges count down
        step_up = pins_reg.a && !pins_prev_reg.a; // R02 R05
        step_dn = pins_reg.b && !pins_prev_reg.b; // R02 R05
        if (step_up && step_dn) begin
          step_up = 1'b0;
          step_dn = 1'b0;
        end
      end
    endcase
  end

  assign zero_hit = pins_reg.zero && !pins_prev_reg.zero; // R06

  // boundary checks on the value after the step (signed compare)
  always_comb begin
    count_next = position_counter_reg;
    if (step_up) begin
      count_next = position_counter_reg + 32'h00000001;
    end else if (step_dn) begin
      count_next = position_counter_reg - 32'h00000001;
    end
  end
  assign max_hit = (step_up || step_dn) && ($signed(count_next) > $signed(maxb_reg)); // R10
  assign min_hit = (step_up || step_dn) && ($signed(count_next) < $signed(minb_reg)); // R10

  // position counter
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      position_counter_reg <= 32'h00000000;
    end else if (wr_en && addr_ok && i_paddr == `QDC_OFS_COUNT) begin
      position_counter_reg <= qdc_merge(position_counter_reg, i_pwdata, i_pstrb);
    end else if (ctrl_reg[`QDC_CTRL_EN]) begin
      if (zero_hit && ctrl_reg[`QDC_CTRL_ZCLR]) begin
        position_counter_reg <= 32'h00000000; // R06
      end else if (ctrl_reg[`QDC_CTRL_AUTOZ] && (max_hit || min_hit)) begin
        position_counter_reg <= 32'h00000000; // R09
      end else begin
        position_counter_reg <= count_next; // R01 R02
      end
    end
  end

  // status set and clear terms for this cycle
  always_comb begin
    st_set = '0;
    st_clr = '0;
    if (ctrl_reg[`QDC_CTRL_EN]) begin
      st_set[`QDC_ST_UP]      = step_up;
      st_set[`QDC_ST_DN]      = step_dn;
      st_set[`QDC_ST_MAXX]    = max_hit; // R10
      st_set[`QDC_ST_MINX]    = min_hit; // R10
      st_set[`QDC_ST_ZERO]    = zero_hit; // R06
      st_set[`QDC_ST_ILLEGAL] = illegal; // R12
    end
    if (wr_en && addr_ok && i_paddr == `QDC_OFS_STATUS && i_pstrb[0]) begin
      st_clr = i_pwdata[`QDC_ST_W-1:0];
    end
  end

  // sticky status: set wins over write-one-to-clear
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      status_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~st_clr) | st_set;
    end
  end

  // interrupt level and timer event forwarding
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_irq       <= 1'b0;
      o_timer_evt <= '0;
    end else begin
      o_irq          <= |(status_reg & mask_reg); // R10
      o_timer_evt.up <= ctrl_reg[`QDC_CTRL_EN] && ctrl_reg[`QDC_CTRL_FWDIR] && step_up; // R08
      o_timer_evt.dn <= ctrl_reg[`QDC_CTRL_EN] && ctrl_reg[`QDC_CTRL_FWDIR] && step_dn; // R08
    end
  end

endmodule
`default_nettype wire

// *** qdc_params.svh ***
// qdc_params.svh: register offsets, field positions, reset values and timing counts
// for the quadrature up/down counter; included by the package and the design.
`ifndef QDC_PARAMS_SVH
`define QDC_PARAMS_SVH

// register byte offsets on the apb slave
`define QDC_OFS_CTRL     12'h000
`define QDC_OFS_COUNT    12'h004
`define QDC_OFS_MAXB     12'h008
`define QDC_OFS_MINB     12'h00c
`define QDC_OFS_DEBOUNCE 12'h010
`define QDC_OFS_STATUS   12'h014
`define QDC_OFS_MASK     12'h018
`define QDC_OFS_INPUTS   12'h01c

// control fields
`define QDC_CTRL_EN      0
`define QDC_CTRL_MODE_LO 1
`define QDC_CTRL_MODE_HI 2
`define QDC_CTRL_AUTOZ   3
`define QDC_CTRL_ZCLR    4
`define QDC_CTRL_FWDIR   5

// mode field codes
`define QDC_MODE_QUAD    2'h0
`define QDC_MODE_BIN     2'h1
`define QDC_MODE_DIR     2'h2
`define QDC_MODE_UPDN    2'h3

// status / mask bit positions
`define QDC_ST_UP        0
`define QDC_ST_DN        1
`define QDC_ST_MAXX      2
`define QDC_ST_MINX      3
`define QDC_ST_ZERO      4
`define QDC_ST_ILLEGAL   5
`define QDC_ST_W         6

// reset values
`define QDC_RST_CTRL     6'h00
`define QDC_RST_MAXB     32'h7fffffff
`define QDC_RST_MINB     32'h80000000
`define QDC_RST_DEBOUNCE 16'h0004

// debounce tick: one tick each 1 us at the 250 MHz core clock
`define QDC_TICK_NS      1000
`define QDC_CLK_NS       4
`define QDC_TICK_CYC     (`QDC_TICK_NS / `QDC_CLK_NS)

`endif

// *** qdc_pkg.sv ***
// qdc_pkg.sv: types shared by the quadrature up/down counter.
// assumes qdc_params.svh is on the include path.
`include "qdc_params.svh"

package qdc_pkg;

  // the three debounced position inputs
  typedef struct packed {
    logic zero;
    logic b;
    logic a;
  } qdc_pins_t;

  // count event forwarded to a general-purpose timer
  typedef struct packed {
    logic up;
    logic dn;
  } qdc_evt_t;

  typedef enum logic [1:0] {
    QDC_QUAD,
    QDC_BIN,
    QDC_DIR,
    QDC_UPDN
  } qdc_mode_t;

endpackage

// *** qdc_counter_asserts.sv ***
// qdc_counter_asserts.sv: port timing checks for qdc_counter.
// assumes the bind below and an apb master that keeps the protocol.
`timescale 1ns/100ps
`default_nettype none
`include "qdc_params.svh"
module qdc_counter_asserts
  import qdc_pkg::*;
(
  input wire logic        i_core_clk,
  input wire logic        i_resetn,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0]  i_pstrb,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic [2:0]  i_position_counter_inputs,
  input wire logic        o_irq,
  input wire qdc_evt_t    o_timer_evt
);
  // access edge: penable seen before the answer
  logic taken;
  assign taken = i_psel && i_penable && !o_pready;
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);
  a_ready_after_access: assert property ($rose(i_penable) && i_psel |=> o_pready)
    else $error("pready late");
  a_ready_needs_access: assert property (!(i_psel && i_penable) |=> !o_pready)
    else $error("pready without access");
  a_err_with_ready: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  a_err_unmapped: assert property (taken && (i_paddr > `QDC_OFS_INPUTS
    || i_paddr[1:0] != 2'h0) |=> o_pslverr && o_prdata == 32'h0) else $error("no pslverr");
  a_irq_mask_off: assert property (taken && i_pwrite && i_paddr == `QDC_OFS_MASK &&
    i_pwdata == 32'h0 && i_pstrb == 4'hf |=> ##2 !o_irq) else $error("irq stays");
  a_evt_one_step: assert property (!(o_timer_evt.up && o_timer_evt.dn))
    else $error("up and down together");
  a_evt_pulse_once: assert property (o_timer_evt != 2'h0 |=> o_timer_evt == 2'h0)
    else $error("event too long");
  a_reset_quiet: assert property ($rose(i_resetn) |-> !o_pready && !o_irq)
    else $error("output after reset");
endmodule
bind qdc_counter qdc_counter_asserts u_chk (
  .i_core_clk, .i_resetn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
  .i_pstrb, .o_prdata, .o_pready, .o_pslverr, .i_position_counter_inputs,
  .o_irq, .o_timer_evt
);
`default_nettype wire

// *** qdc_encoder_model.sv ***
// qdc_encoder_model.sv: encoder, thumbwheel and marker pins moved on command.
// assumes the bench pulses i_go for one cycle per action.
`timescale 1ns/100ps
`default_nettype none
module qdc_encoder_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_go,
  input  wire logic [2:0] i_act,
  output logic      [2:0] o_pins
);
  // pins as {zero, b, a}; each action moves them once
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pins <= 3'h0;
    end else if (i_go) begin
      case (i_act)
        3'h0: o_pins[1:0] <= {o_pins[0], ~o_pins[1]};
        3'h1: o_pins[1:0] <= {~o_pins[0], o_pins[1]};
        3'h2: o_pins[1:0] <= ~o_pins[1:0];
        3'h3: o_pins[2] <= ~o_pins[2];
        3'h4: o_pins[1] <= ~o_pins[1];
        3'h5: o_pins[0] <= ~o_pins[0];
        default: o_pins[1:0] <= o_pins[1:0] + 2'h1;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** qdc_counter_tb_top.sv ***
// qdc_counter_tb_top.sv: self-checking bench for qdc_counter.
// assumes qdc_encoder_model on the pins and the bound checker.
`timescale 1ns/100ps
`default_nettype none
`include "qdc_params.svh"
module qdc_counter_tb_top
  import qdc_pkg::*;
;
  typedef struct packed {
    logic [5:0] ctrl;
    logic [2:0] act;
    logic [1:0] dir;
    logic [5:0] st;
  } qdc_row_t;
  logic        clk, i_resetn, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_irq, go, err;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd, exp_cnt;
  logic [3:0]  i_pstrb;
  logic [2:0]  i_position_counter_inputs, act;
  qdc_evt_t    o_timer_evt;
  int          errors, samples_checked, cyc, n_up, n_dn, e_up, e_dn;
  qdc_row_t    rows [16];
  qdc_counter uut (.i_core_clk(clk), .i_resetn, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .i_pstrb, .o_prdata, .o_pready, .o_pslverr, .i_position_counter_inputs,
    .o_irq, .o_timer_evt);
  qdc_encoder_model u_enc (.i_core_clk(clk), .i_resetn, .i_go(go), .i_act(act),
    .o_pins(i_position_counter_inputs));
  // free-running core clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // tally forwarded events; cut a hang short
  always @(posedge clk) begin
    n_up += (o_timer_evt.up === 1'b1);
    n_dn += (o_timer_evt.dn === 1'b1);
    cyc++;
    if (cyc > 30000) begin
      errors++;
      wrap_up();
    end
  end
  // one apb transfer: setup, access until pready, then release
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    i_penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (o_pready !== 1'b1 && n < 20);
    rd = o_prdata;
    err = o_pslverr;
    {i_psel, i_penable} <= 2'h0;
    if (n >= 20) errors++;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chkb(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  // one pin action, then a settling wait
  task automatic step(input logic [2:0] a, input int w);
    @(posedge clk);
    {act, go} <= {a, 1'b1};
    @(posedge clk);
    go <= 1'b0;
    repeat (w) @(posedge clk);
  endtask
  task automatic wrap_up();
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // reset, table of modes, then the awkward cases
  initial begin
    {i_resetn, i_psel, i_penable, i_pwrite, go, act, i_paddr, i_pwdata, exp_cnt} = '0;
    i_pstrb = 4'hf;
    rows = '{'{6'h21, 3'h0, 2'h1, 6'h01}, '{6'h21, 3'h0, 2'h1, 6'h01},
      '{6'h21, 3'h1, 2'h2, 6'h02}, '{6'h21, 3'h2, 2'h0, 6'h20},
      '{6'h23, 3'h6, 2'h1, 6'h01}, '{6'h23, 3'h2, 2'h1, 6'h01},
      '{6'h23, 3'h6, 2'h1, 6'h01}, '{6'h25, 3'h5, 2'h0, 6'h00},
      '{6'h25, 3'h5, 2'h1, 6'h01}, '{6'h25, 3'h4, 2'h0, 6'h00},
      '{6'h25, 3'h5, 2'h0, 6'h00}, '{6'h25, 3'h5, 2'h2, 6'h02},
      '{6'h27, 3'h5, 2'h0, 6'h00}, '{6'h27, 3'h5, 2'h1, 6'h01},
      '{6'h27, 3'h4, 2'h0, 6'h00}, '{6'h27, 3'h4, 2'h2, 6'h02}};
    repeat (4) @(posedge clk);
    i_resetn <= 1'b1;
    rdchk(`QDC_OFS_CTRL, {26'h0, `QDC_RST_CTRL});
    rdchk(`QDC_OFS_MAXB, `QDC_RST_MAXB);
    rdchk(`QDC_OFS_MINB, `QDC_RST_MINB);
    rdchk(`QDC_OFS_DEBOUNCE, {16'h0, `QDC_RST_DEBOUNCE});
    apb(1'b1, `QDC_OFS_DEBOUNCE, 32'h0);
    foreach (rows[i]) begin
      apb(1'b1, `QDC_OFS_CTRL, {26'h0, rows[i].ctrl});
      step(rows[i].act, 20);
      if (rows[i].dir == 2'h1) {exp_cnt, e_up} = {exp_cnt + 32'h1, e_up + 1};
      if (rows[i].dir == 2'h2) {exp_cnt, e_dn} = {exp_cnt - 32'h1, e_dn + 1};
      rdchk(`QDC_OFS_COUNT, exp_cnt);
      rdchk(`QDC_OFS_STATUS, {26'h0, rows[i].st});
      apb(1'b1, `QDC_OFS_STATUS, 32'h3f);
    end
    chk(n_up, e_up);
    chk(n_dn, e_dn);
    apb(1'b1, `QDC_OFS_CTRL, 32'h21);
    apb(1'b1, `QDC_OFS_DEBOUNCE, 32'h4);
    step(3'h0, 500);
    step(3'h1, 1600);
    rdchk(`QDC_OFS_COUNT, exp_cnt);
    step(3'h0, 1600);
    rdchk(`QDC_OFS_COUNT, exp_cnt + 32'h1);
    apb(1'b1, `QDC_OFS_DEBOUNCE, 32'h0);
    apb(1'b1, `QDC_OFS_MAXB, exp_cnt + 32'h2);
    apb(1'b1, `QDC_OFS_CTRL, 32'h29);
    apb(1'b1, `QDC_OFS_STATUS, 32'h3f);
    apb(1'b1, `QDC_OFS_MASK, 32'h4);
    step(3'h0, 20);
    rdchk(`QDC_OFS_STATUS, 32'h1);
    chkb(o_irq, 1'b0);
    step(3'h0, 20);
    rdchk(`QDC_OFS_COUNT, 32'h0);
    rdchk(`QDC_OFS_STATUS, 32'h5);
    chkb(o_irq, 1'b1);
    apb(1'b1, `QDC_OFS_MASK, 32'h0);
    repeat (2) @(posedge clk);
    chkb(o_irq, 1'b0);
    apb(1'b1, `QDC_OFS_MASK, 32'h4);
    repeat (2) @(posedge clk);
    chkb(o_irq, 1'b1);
    apb(1'b1, `QDC_OFS_STATUS, 32'h4);
    rdchk(`QDC_OFS_STATUS, 32'h1);
    chkb(o_irq, 1'b0);
    apb(1'b1, `QDC_OFS_CTRL, 32'h21);
    apb(1'b1, `QDC_OFS_MINB, 32'hffffffff);
    apb(1'b1, `QDC_OFS_STATUS, 32'h3f);
    step(3'h1, 20);
    step(3'h1, 20);
    rdchk(`QDC_OFS_COUNT, 32'hfffffffe);
    rdchk(`QDC_OFS_STATUS, 32'ha);
    apb(1'b1, `QDC_OFS_CTRL, 32'h11);
    apb(1'b1, `QDC_OFS_STATUS, 32'h3f);
    step(3'h3, 20);
    rdchk(`QDC_OFS_COUNT, 32'h0);
    rdchk(`QDC_OFS_STATUS, 32'h10);
    rdchk(`QDC_OFS_INPUTS, {29'h0, i_position_counter_inputs});
    apb(1'b1, `QDC_OFS_CTRL, 32'h03);
    step(3'h4, 20);
    rdchk(`QDC_OFS_COUNT, 32'h0);
    rdchk(`QDC_OFS_STATUS, 32'h30);
    apb(1'b1, `QDC_OFS_COUNT, 32'h89abcdef);
    rdchk(`QDC_OFS_COUNT, 32'h89abcdef);
    apb(1'b0, 12'h020, 32'h0);
    chkb(err, 1'b1);
    chk(rd, 32'h0);
    @(posedge clk);
    i_resetn <= 1'b0;
    repeat (2) @(posedge clk);
    i_resetn <= 1'b1;
    rdchk(`QDC_OFS_COUNT, 32'h0);
    wrap_up();
  end
endmodule
`default_nettype wire
